/* File: verilog/fsmon_top.sv */
// fsmon_top: fail-safe clock monitor and device clock selection
// assumes: primary and RC clocks arrive as asynchronous pins, the
// wake request as an asynchronous level, registers over a plain port
//
// The plain strobed port and the register offsets are this design's own decisions.
`include "fsmon_map.svh"

module fsmon_top #(
  parameter int unsigned PLL_LOCK_CYC = `FSMON_PLL_LOCK_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // register port
  input fsmon_pkg::fsmon_req_s req_i,
  output logic [`FSMON_DATA_W-1:0] rd_data_o,
  // oscillator pins
  input wire logic prim_clk_i,
  input wire logic rc_clk_i,
  // interrupt and wake request
  input wire logic wake_irq_i,
  // clock control outputs
  output logic clk_sel_rc_o,
  output logic prim_osc_en_o,
  output logic cpu_run_o,
  output logic monitor_on_o,
  output logic fail_flag_o
);

  import fsmon_pkg::*;

  localparam logic [17:0] PLL_END = 18'(PLL_LOCK_CYC);

  // synchronisers: only stage 2 (bit 1) is read by logic
  logic [1:0] prim_sync;
  logic [1:0] rc_sync;
  logic [1:0] irq_sync;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prim_sync <= 2'h0;
      rc_sync <= 2'h0;
      irq_sync <= 2'h0;
    end else begin
      prim_sync <= {prim_sync[0], prim_clk_i};
      rc_sync <= {rc_sync[0], rc_clk_i};
      irq_sync <= {irq_sync[0], wake_irq_i};
    end
  end

  logic prim_rise;
  logic fail_pulse;

  fsmon_sampler u_sampler (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(monitor_on_o),
    .prim_lvl_i(prim_sync[1]),
    .rc_lvl_i(rc_sync[1]),
    .prim_rise_o(prim_rise),
    .fail_o(fail_pulse)
  );

  fsmon_ck_e ck_q;
  fsmon_ck_e next_ck;
  fsmon_pwr_e pwr_q;
  fsmon_pwr_e next_pwr;
  fsmon_ctrl_s ctrl_q;
  fsmon_ctrl_s next_ctrl;
  logic fail_q;
  logic next_fail;
  logic [10:0] ost_cnt;
  logic [10:0] next_ost;
  logic [17:0] pll_cnt;
  logic [17:0] next_pll;
  logic [`FSMON_DATA_W-1:0] next_rd;
  logic [`FSMON_DATA_W-1:0] stat_v;
  logic next_sel_rc;
  logic next_osc_en;
  logic next_run;
  logic next_mon;
  logic ctrl_wr;
  logic stat_wr;
  logic crystal;
  logic alt_req;
  logic fail_hit;

  always_comb begin
    ctrl_wr = req_i.wr && (req_i.addr == `FSMON_CTRL_OFS);
    stat_wr = req_i.wr && (req_i.addr == `FSMON_STAT_OFS);
    crystal = ctrl_q.osc inside {OSC_STD_CRYSTAL, OSC_FAST_CRYSTAL,
                                 OSC_FAST_CRYSTAL_MULT};
    fail_hit = fail_pulse && monitor_on_o;
    alt_req = ctrl_wr && req_i.wdata[`FSMON_C_SRC] &&
              (req_i.wdata[`FSMON_C_PWR_LO +: 2] == `FSMON_PWR_IDLE_CODE);
    next_ctrl = ctrl_q;
    next_pwr = pwr_q;
    next_ck = ck_q;
    next_ost = ost_cnt;
    next_pll = pll_cnt;
    next_fail = fail_q;

    // power mode requests from software
    if (ctrl_wr) begin
      next_ctrl = fsmon_ctrl_s'(req_i.wdata);
      next_ctrl.spare = 1'b0;
      case (req_i.wdata[`FSMON_C_PWR_LO +: 2])
        `FSMON_PWR_IDLE_CODE: begin
          next_pwr = PWR_IDLE;
        end
        `FSMON_PWR_SLEEP_CODE: begin
          next_pwr = PWR_SLEEP;
        end
        default: begin
          next_pwr = PWR_RUN;
        end
      endcase
    end

    // leaving idle or sleep
    if (pwr_q == PWR_IDLE) begin
      if (irq_sync[1]) begin
        next_pwr = PWR_RUN;
      end
      if (fail_q && ctrl_q.fail_int_en) begin
        next_pwr = PWR_RUN;
      end
    end
    if (pwr_q == PWR_SLEEP && irq_sync[1]) begin
      next_pwr = PWR_RUN;
    end

    case (ck_q)
      CK_START: begin
        if (alt_req) begin
          next_ck = CK_ALT;
        end else if (next_pwr == PWR_SLEEP) begin
          next_ck = CK_SLEEP;
        end else if (!crystal) begin
          next_ck = CK_PRIMARY;
        end else if (ost_cnt != `FSMON_OST_EDGES) begin
          if (prim_rise) begin
            next_ost = ost_cnt + 11'h1;
          end
        end else if (ctrl_q.osc == OSC_FAST_CRYSTAL_MULT &&
                     pll_cnt != PLL_END) begin
          next_pll = pll_cnt + 18'h1;
        end else begin
          next_ck = CK_PRIMARY;
        end
      end
      CK_PRIMARY: begin
        if (fail_hit) begin
          next_ck = CK_FAILED;
        end else if (next_pwr == PWR_SLEEP) begin
          next_ck = CK_SLEEP;
        end
      end
      CK_ALT: begin
        if (next_pwr == PWR_SLEEP) begin
          next_ck = CK_SLEEP;
        end
      end
      CK_SLEEP: begin
        // wake restarts the whole start-up sequence
        if (next_pwr == PWR_RUN) begin
          next_ck = CK_START;
          next_ost = 11'h0;
          next_pll = 18'h0;
        end
      end
      CK_FAILED: begin
        next_ck = CK_FAILED;
      end
      default: begin
        next_ck = CK_START;
      end
    endcase

    // set wins over a same-cycle clear
    if (stat_wr && req_i.wdata[`FSMON_S_FAIL]) begin
      next_fail = 1'b0;
    end
    if (fail_hit) begin
      next_fail = 1'b1;
    end

    next_sel_rc = (next_ck != CK_PRIMARY) || next_ctrl.src_rc;
    next_osc_en = (next_ck == CK_START) || (next_ck == CK_PRIMARY);
    next_run = (next_pwr == PWR_RUN);
    // masked throughout start-up, so a dead crystal raises nothing
    next_mon = (next_ck == CK_PRIMARY) && !next_ctrl.src_rc;

    stat_v = '0;
    stat_v[`FSMON_S_STABLE] = (ck_q == CK_PRIMARY);
    stat_v[`FSMON_S_FAIL] = fail_q;
    stat_v[`FSMON_S_ON_RC] = clk_sel_rc_o;
    stat_v[`FSMON_S_MON] = monitor_on_o;
    stat_v[`FSMON_S_PWR_LO +: 2] = pwr_q;
    next_rd = '0;
    if (req_i.rd) begin
      case (req_i.addr)
        `FSMON_CTRL_OFS: begin
          next_rd = ctrl_q;
        end
        `FSMON_STAT_OFS: begin
          next_rd = stat_v;
        end
        default: begin
          next_rd = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ck_q <= CK_START;
      pwr_q <= PWR_RUN;
      ctrl_q <= fsmon_ctrl_s'(`FSMON_CTRL_RST);
      fail_q <= 1'b0;
      ost_cnt <= 11'h0;
      pll_cnt <= 18'h0;
      rd_data_o <= '0;
      clk_sel_rc_o <= 1'b1;
      prim_osc_en_o <= 1'b1;
      cpu_run_o <= 1'b1;
      monitor_on_o <= 1'b0;
      fail_flag_o <= 1'b0;
    end else begin
      ck_q <= next_ck;
      pwr_q <= next_pwr;
      ctrl_q <= next_ctrl;
      fail_q <= next_fail;
      ost_cnt <= next_ost;
      pll_cnt <= next_pll;
      rd_data_o <= next_rd;
      clk_sel_rc_o <= next_sel_rc;
      prim_osc_en_o <= next_osc_en;
      cpu_run_o <= next_run;
      monitor_on_o <= next_mon;
      fail_flag_o <= next_fail;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_mux_follows_ctrl: assert property (
    ck_q == CK_PRIMARY |-> clk_sel_rc_o == ctrl_q.src_rc)
    else $error("clock mux does not follow control source");

  chk_fail_no_return: assert property (
    ck_q == CK_FAILED |=> ck_q == CK_FAILED && clk_sel_rc_o)
    else $error("left failed state without reset");

  chk_fail_int_wake: assert property (
    pwr_q == PWR_IDLE && fail_q && ctrl_q.fail_int_en |=> cpu_run_o)
    else $error("enabled failure did not resume execution");

  chk_idle_irq_run: assert property (
    pwr_q == PWR_IDLE && irq_sync[1] |=> cpu_run_o ##0 pwr_q == PWR_RUN)
    else $error("interrupt in idle did not restart execution");

  chk_direct_monitor: assert property (
    ck_q == CK_START && !crystal && !alt_req && next_pwr != PWR_SLEEP
    |=> ck_q == CK_PRIMARY)
    else $error("non-crystal start did not go straight to monitoring");

  chk_start_on_rc: assert property (
    ck_q == CK_START |-> clk_sel_rc_o && prim_osc_en_o)
    else $error("start-up not running from internal rc");

  chk_timers_expired: assert property (
    ck_q == CK_PRIMARY && $past(ck_q) == CK_START && $past(crystal)
    |-> ost_cnt == `FSMON_OST_EDGES)
    else $error("primary released before start-up timer expired");

  chk_rc_reference: assert property (
    ck_q == CK_PRIMARY && !ctrl_q.src_rc |-> monitor_on_o && !clk_sel_rc_o)
    else $error("stable primary not monitored by rc reference");

  chk_start_masked: assert property (
    ck_q == CK_START |-> !monitor_on_o ##1 !$rose(fail_flag_o))
    else $error("failure detection active during start-up");

  chk_alt_stops_osc: assert property (
    ck_q == CK_START && alt_req |=> !prim_osc_en_o && ck_q == CK_ALT)
    else $error("primary not disabled on alternate mode");

  chk_fail_switch: assert property (
    ck_q == CK_PRIMARY && fail_hit
    |=> fail_flag_o && clk_sel_rc_o && ck_q == CK_FAILED)
    else $error("failure did not flag and switch to rc");

  cov_failure: cover property (ck_q == CK_PRIMARY ##1 ck_q == CK_FAILED);
  cov_wake: cover property (ck_q == CK_SLEEP ##1 ck_q == CK_START);
  cov_alt: cover property (ck_q == CK_START ##1 ck_q == CK_ALT);
  cov_pll_wait: cover property (
    ck_q == CK_START && ctrl_q.osc == OSC_FAST_CRYSTAL_MULT
    ##1 ck_q == CK_PRIMARY);

endmodule

/* File: verilog/fsmon_map.svh */
// fsmon_map.svh: offsets, field positions, reset values, timing counts
// assumes: included by bare name from the package and the design files
// How it works
// - entering idle selects the source named in the oscillator control register, sleep the internal RC; monitoring continues only on the primary.
// - a failure with the failure interrupt enabled keeps code running on the internal RC clock and never returns to the failed source.
// - after a failure with the interrupt disabled, any interrupt in idle restarts execution clocked by the internal RC.
// - failure can be caught once monitoring starts after reset or wake, and it starts at once for the external clock or internal RC modes.
// - crystal modes run from the internal RC after reset or wake until the start-up timer has expired, and in the multiplier mode the PLL lock timer too.
// - once the primary clock is stable the internal RC stops being the device clock and becomes the monitor's sampling reference.
// - the start-up masking also hides an oscillator that never starts, so no failure flag is raised then.
// - choosing another clock and power-managed mode while the primary is still stabilising disables the primary at once.
`ifndef FSMON_MAP_SVH
`define FSMON_MAP_SVH

`define FSMON_ADDR_W 4
`define FSMON_DATA_W 8
`define FSMON_CTRL_OFS 4'h0
`define FSMON_STAT_OFS 4'h4
`define FSMON_CTRL_RST 8'h20

// control fields
`define FSMON_C_SRC 0
`define FSMON_C_PWR_LO 1
`define FSMON_C_FIE 3
`define FSMON_C_OSC_LO 4

// status fields
`define FSMON_S_STABLE 0
`define FSMON_S_FAIL 1
`define FSMON_S_ON_RC 2
`define FSMON_S_MON 3
`define FSMON_S_PWR_LO 4

// power request codes in the control register
`define FSMON_PWR_IDLE_CODE 2'h1
`define FSMON_PWR_SLEEP_CODE 2'h2

// timing
`define FSMON_CLK_MHZ 125
`define FSMON_OST_EDGES 11'h400
`define FSMON_PLL_LOCK_US 2000
`define FSMON_PLL_LOCK_CYC (`FSMON_PLL_LOCK_US * `FSMON_CLK_MHZ)
`define FSMON_MISS_TICKS 2'h2

`endif

/* File: verilog/fsmon_pkg.sv */
// fsmon_pkg: types shared by the clock monitor files
// assumes: fsmon_map.svh is on the include path
`include "fsmon_map.svh"

package fsmon_pkg;

  typedef enum logic [2:0] {
    OSC_EXT_CLOCK,
    OSC_INT_RC,
    OSC_STD_CRYSTAL,
    OSC_FAST_CRYSTAL,
    OSC_FAST_CRYSTAL_MULT
  } fsmon_osc_e;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_IDLE,
    PWR_SLEEP
  } fsmon_pwr_e;

  typedef enum logic [2:0] {
    CK_START,
    CK_PRIMARY,
    CK_FAILED,
    CK_ALT,
    CK_SLEEP
  } fsmon_ck_e;

  typedef struct packed {
    logic spare;
    fsmon_osc_e osc;
    logic fail_int_en;
    logic [1:0] pwr_req;
    logic src_rc;
  } fsmon_ctrl_s;

  typedef struct packed {
    logic [`FSMON_ADDR_W-1:0] addr;
    logic [`FSMON_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } fsmon_req_s;

endpackage

/* File: verilog/fsmon_sampler.sv */
// fsmon_sampler: checks primary edges against internal RC ticks
// assumes: both level inputs already passed a two-stage synchroniser
`include "fsmon_map.svh"

module fsmon_sampler (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // control
  input wire logic enable_i,
  // synchronised clock levels
  input wire logic prim_lvl_i,
  input wire logic rc_lvl_i,
  // results
  output logic prim_rise_o,
  output logic fail_o
);

  logic prim_q;
  logic rc_q;
  logic seen;
  logic next_seen;
  logic [1:0] miss;
  logic [1:0] next_miss;
  logic next_fail;
  logic rc_rise;

  // edges only visible below half the system clock rate
  always_comb begin
    prim_rise_o = prim_lvl_i && !prim_q;
    rc_rise = rc_lvl_i && !rc_q;
    next_seen = seen;
    next_miss = miss;
    next_fail = 1'b0;
    if (!enable_i) begin
      next_seen = 1'b0;
      next_miss = 2'h0;
    end else begin
      if (rc_rise) begin
        next_seen = 1'b0;
        if (seen) begin
          next_miss = 2'h0;
        end else if (miss == `FSMON_MISS_TICKS - 2'h1) begin
          // two empty windows so a phase slip on enable is not a failure
          next_fail = 1'b1;
          next_miss = 2'h0;
        end else begin
          next_miss = miss + 2'h1;
        end
      end
      if (prim_rise_o) begin
        next_seen = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prim_q <= 1'b0;
      rc_q <= 1'b0;
      seen <= 1'b0;
      miss <= 2'h0;
      fail_o <= 1'b0;
    end else begin
      prim_q <= prim_lvl_i;
      rc_q <= rc_lvl_i;
      seen <= next_seen;
      miss <= next_miss;
      fail_o <= next_fail;
    end
  end

endmodule

/* File: sim/fsmon_osc_model.sv */
// fsmon_osc_model: primary oscillator part and internal RC source
// assumes: the bench gates the primary with alive_i, the design with en_i
module fsmon_osc_model (
  // control
  input wire logic en_i,
  input wire logic alive_i,
  // clocks
  output logic prim_clk_o,
  output logic rc_clk_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // rc slower than primary, both well below the sampling limit
  initial begin
    rc_clk_o = 1'b0;
    forever #100 rc_clk_o = ~rc_clk_o;
  end

  // a disabled or dead crystal stands low, it never keeps toggling
  initial begin
    prim_clk_o = 1'b0;
    forever begin
      #20;
      prim_clk_o = (en_i && alive_i) ? ~prim_clk_o : 1'b0;
    end
  end
endmodule

/* File: sim/testbench.sv */
// testbench: scenario tasks for the fail-safe clock monitor
// assumes: fsmon_pkg compiled first, fsmon_map.svh on the include path
`include "fsmon_map.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fsmon_pkg::*;

  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  fsmon_req_s req = '0;
  logic wake = 1'b0;
  logic alive = 1'b0;
  logic [7:0] rdata;
  logic [7:0] rdv;
  logic prim_clk, rc_clk, sel_rc, osc_en, cpu_run, mon_on, fail;
  int err_count = 0;
  int n_checks = 0;

  fsmon_top #(.PLL_LOCK_CYC(20)) i_dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .req_i(req),
    .rd_data_o(rdata), .prim_clk_i(prim_clk), .rc_clk_i(rc_clk),
    .wake_irq_i(wake), .clk_sel_rc_o(sel_rc), .prim_osc_en_o(osc_en),
    .cpu_run_o(cpu_run), .monitor_on_o(mon_on), .fail_flag_o(fail)
  );

  fsmon_osc_model i_osc (
    .en_i(osc_en), .alive_i(alive),
    .prim_clk_o(prim_clk), .rc_clk_o(rc_clk)
  );

  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic do_reset();
    sys_rst_i <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk_sys_i);
    req.wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_sys_i);
    req.rd <= 1'b0;
    #1;
    rdv = rdata;
    @(posedge clk_sys_i);
  endtask

  task automatic wait_stable(output int n);
    n = 0;
    rd(`FSMON_STAT_OFS);
    while (rdv[0] !== 1'b1 && n < 4000) begin
      rd(`FSMON_STAT_OFS);
      n++;
    end
  endtask

  task automatic wait_fail();
    for (int i = 0; i < 300 && fail !== 1'b1; i++) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic t_start();
    int n;
    alive <= 1'b0;
    do_reset();
    rd(`FSMON_CTRL_OFS);
    chk("ctrl reset", rdv, `FSMON_CTRL_RST);
    repeat (3000) @(posedge clk_sys_i);
    #1;
    chk("dead flag", fail, 1'b0);
    chk("start on rc", sel_rc, 1'b1);
    rd(`FSMON_STAT_OFS);
    chk("no stable", rdv[0], 1'b0);
    alive <= 1'b1;
    wait_stable(n);
    chk("poll bound", n < 4000, 1'b1);
    chk("status run", rdv, 8'h09);
    chk("off rc", sel_rc, 1'b0);
    chk("mon on", mon_on, 1'b1);
  endtask

  task automatic t_fail_idle();
    wr(`FSMON_CTRL_OFS, 8'h22);
    chk("idle halt", cpu_run, 1'b0);
    chk("idle src", sel_rc, 1'b0);
    rd(`FSMON_STAT_OFS);
    chk("idle stat", rdv, 8'h19);
    alive <= 1'b0;
    wait_fail();
    chk("flag", fail, 1'b1);
    chk("to rc", sel_rc, 1'b1);
    chk("osc off", osc_en, 1'b0);
    chk("still idle", cpu_run, 1'b0);
    wake <= 1'b1;
    for (int i = 0; i < 10 && cpu_run !== 1'b1; i++) @(posedge clk_sys_i);
    wake <= 1'b0;
    #1;
    chk("wake run", cpu_run, 1'b1);
    chk("wake rc", sel_rc, 1'b1);
    alive <= 1'b1;
    repeat (500) @(posedge clk_sys_i);
    chk("no return", sel_rc, 1'b1);
  endtask

  task automatic t_fail_fie();
    t_start();
    wr(`FSMON_CTRL_OFS, 8'h2a);
    alive <= 1'b0;
    wait_fail();
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("fie run", cpu_run, 1'b1);
    chk("fie rc", sel_rc, 1'b1);
    chk("fie flag", fail, 1'b1);
    // write one clears the flag, state stays on rc
    wr(`FSMON_STAT_OFS, 8'h02);
    chk("flag clear", fail, 1'b0);
    rd(`FSMON_STAT_OFS);
    chk("fail stat", rdv, 8'h04);
    rd(4'h8);
    chk("unmapped", rdv, 8'h00);
    wr(4'h8, 8'hff);
    wr(`FSMON_CTRL_OFS, 8'haa);
    rd(`FSMON_CTRL_OFS);
    chk("ctrl bit7", rdv, 8'h2a);
    // read data stand one cycle only
    #1;
    chk("rd clears", rdata, 8'h00);
  endtask

  task automatic t_ext_wake();
    int n;
    alive <= 1'b1;
    do_reset();
    wait_stable(n);
    wr(`FSMON_CTRL_OFS, 8'h04);
    chk("sleep", cpu_run, 1'b0);
    wake <= 1'b1;
    for (int i = 0; i < 10 && cpu_run !== 1'b1; i++) @(posedge clk_sys_i);
    wake <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk("ext prim", sel_rc, 1'b0);
    chk("ext mon", mon_on, 1'b1);
  endtask

  // sleep into multiplier crystal mode, wake through both timers
  task automatic t_pll();
    int n;
    wr(`FSMON_CTRL_OFS, 8'h44);
    wake <= 1'b1;
    for (int i = 0; i < 10 && cpu_run !== 1'b1; i++) @(posedge clk_sys_i);
    wake <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk("pll start rc", sel_rc, 1'b1);
    chk("pll no mon", mon_on, 1'b0);
    wait_stable(n);
    chk("pll bound", n < 4000, 1'b1);
    chk("pll off rc", sel_rc, 1'b0);
    chk("pll mon", mon_on, 1'b1);
    wr(`FSMON_CTRL_OFS, 8'h43);
    chk("idle rc src", sel_rc, 1'b1);
    chk("idle rc halt", cpu_run, 1'b0);
  endtask

  task automatic t_alt();
    alive <= 1'b1;
    do_reset();
    repeat (5) @(posedge clk_sys_i);
    wr(`FSMON_CTRL_OFS, 8'h23);
    chk("alt osc", osc_en, 1'b0);
    chk("alt halt", cpu_run, 1'b0);
    chk("alt rc", sel_rc, 1'b1);
  endtask

  initial begin
    repeat (90000) @(posedge clk_sys_i);
    err_count++;
    end_of_test();
  end

  initial begin
    t_start();
    t_fail_idle();
    t_fail_fie();
    t_ext_wake();
    t_pll();
    t_alt();
    end_of_test();
  end
endmodule
